// ---- verilog/plbt_servicer.sv ----
// Pass-through servicer: local logic with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module plbt_servicer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Local-bus pins
	plbt_pin_if.servicer     pins
);
	plbt_pkg::plbt_host_state_type state_r;
	plbt_pkg::plbt_host_state_type state_nxt;

	logic [31:0]      ctrl_r;
	logic [3:0][31:0] supply_r;
	logic [3:0][31:0] capture_r;
	logic [31:0]      addr_cap_r;
	logic [31:0]      dq_r;
	logic [1:0]       ptr_r;
	logic [1:0]       lane_r;
	logic [3:0]       cnt_r;
	logic             dir_r;
	logic [1:0]       region_r;
	logic             aw_got_r;
	logic             w_got_r;
	logic [7:0]       awaddr_r;
	logic [31:0]      wdata_r;
	logic [3:0]       wstrb_r;
	logic [31:0]      wmask;

	wire logic [3:0] pend = ~pins.pending_byte_mask_n;
	wire logic pend_any = |pend;
	wire logic [1:0] lane_idx = pend[0] ? 2'h0 : pend[1] ? 2'h1
		: pend[2] ? 2'h2 : 2'h3;
	wire logic in_rdreq = (state_r == plbt_pkg::H_RDREQ) && pend_any;
	wire logic in_phase = (state_r == plbt_pkg::H_PHASE);
	wire logic host_rd_phase = in_phase && !dir_r;
	wire logic last_phase = in_phase && pins.multi_phase_n;
	wire logic [1:0] ptr_nxt = (state_r == plbt_pkg::H_IDLE) ? 2'h0
		: (in_phase && !last_phase) ? ptr_r + 2'h1 : ptr_r;
	wire plbt_pkg::plbt_host_state_type data_first = dir_r ? plbt_pkg::H_RDREQ
		: (ctrl_r[plbt_pkg::PLBT_CTRL_WAIT] ? plbt_pkg::H_WAIT
		: plbt_pkg::H_PHASE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			plbt_pkg::H_IDLE: begin
				if (ctrl_r[plbt_pkg::PLBT_CTRL_ENABLE]
						&& !pins.passthru_attention_n) begin
					state_nxt = ctrl_r[plbt_pkg::PLBT_CTRL_FETCH]
						? plbt_pkg::H_ADDR : plbt_pkg::H_TURN;
				end
			end
			plbt_pkg::H_ADDR:  state_nxt = plbt_pkg::H_TURN;
			plbt_pkg::H_TURN:  state_nxt = data_first;
			plbt_pkg::H_RDREQ: state_nxt = pend_any ? plbt_pkg::H_RDCAP
				: plbt_pkg::H_PHASE;
			plbt_pkg::H_RDCAP: state_nxt = plbt_pkg::H_RDREQ;
			plbt_pkg::H_WAIT:  state_nxt = plbt_pkg::H_PHASE;
			plbt_pkg::H_PHASE: state_nxt = last_phase ? plbt_pkg::H_END
				: data_first;
			plbt_pkg::H_END: begin
				if (pins.passthru_attention_n) begin
					state_nxt = plbt_pkg::H_IDLE;
				end
			end
			default: state_nxt = plbt_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r    <= plbt_pkg::H_IDLE;
			ptr_r      <= 2'h0;
			lane_r     <= 2'h0;
			cnt_r      <= 4'h0;
			dir_r      <= 1'b0;
			region_r   <= 2'h0;
			addr_cap_r <= plbt_pkg::PLBT_WORD_ZERO;
			dq_r       <= plbt_pkg::PLBT_WORD_ZERO;
			capture_r  <= '0;
		end else begin
			state_r <= state_nxt;
			ptr_r   <= ptr_nxt;
			dq_r    <= supply_r[ptr_nxt];
			lane_r  <= lane_idx;
			if (state_r == plbt_pkg::H_IDLE) begin
				dir_r    <= pins.transfer_direction;
				region_r <= pins.region_index;
				// Cleared only when a new access shows up, so the phase
				// count of the latest access stays readable afterwards.
				if (!pins.passthru_attention_n) begin
					cnt_r <= 4'h0;
				end
			end
			if (in_phase) begin
				cnt_r <= cnt_r + 4'h1;
			end
			if (state_r == plbt_pkg::H_ADDR) begin
				addr_cap_r <= pins.dq;
			end
			if (state_r == plbt_pkg::H_RDCAP) begin
				capture_r[ptr_r][lane_r*8 +: 8] <= pins.dq[7:0];
			end
		end
	end

	// Local-bus strobes idle high outside their state; reg_index idles at PLBT_IDX_NONE and loc_dq_oe low.
	assign pins.addr_strobe_n = (state_r != plbt_pkg::H_ADDR);
	assign pins.phase_done_n  = !in_phase;
	assign pins.rd_n          = !in_rdreq;
	assign pins.wr_n          = !host_rd_phase;
	assign pins.chip_select_n = !(in_rdreq || host_rd_phase);
	assign pins.reg_index     = (in_rdreq || host_rd_phase)
		? plbt_pkg::PLBT_DATA_PORT_IDX : plbt_pkg::PLBT_IDX_NONE;
	assign pins.lane_enable_n = in_rdreq ? ~(4'h1 << lane_idx)
		: host_rd_phase ? pins.pending_byte_mask_n
		: plbt_pkg::PLBT_MASK_NONE;
	assign pins.loc_dq_oe     = host_rd_phase;
	assign pins.loc_dq_out    = dq_r;

	// AXI4-Lite write path.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
			assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
		end
	endgenerate

	wire logic do_write = aw_got_r && w_got_r && !s_axi_bvalid;
	wire logic wr_ctrl = (awaddr_r == plbt_pkg::PLBT_REG_CTRL);
	wire logic wr_sup = (awaddr_r[7:4] == plbt_pkg::PLBT_SUPPLY_PAGE)
		&& (awaddr_r[1:0] == 2'h0);
	wire logic [31:0] ctrl_new = ((ctrl_r & ~wmask) | (wdata_r & wmask))
		& plbt_pkg::PLBT_CTRL_MASK;
	wire logic [31:0] sup_new = (supply_r[awaddr_r[3:2]] & ~wmask)
		| (wdata_r & wmask);

	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_r && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_got_r     <= 1'b0;
			w_got_r      <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= plbt_pkg::PLBT_WORD_ZERO;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= plbt_pkg::PLBT_RESP_OKAY;
			ctrl_r       <= plbt_pkg::PLBT_CTRL_RST;
			supply_r     <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ctrl || wr_sup) ? plbt_pkg::PLBT_RESP_OKAY
					: plbt_pkg::PLBT_RESP_SLVERR;
				if (wr_ctrl) begin
					ctrl_r <= ctrl_new;
				end
				if (wr_sup) begin
					supply_r[awaddr_r[3:2]] <= sup_new;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path.
	wire logic [7:0] ra = s_axi_araddr;
	wire logic ra_word = (ra[1:0] == 2'h0);
	wire logic rd_sup = ra_word && (ra[7:4] == plbt_pkg::PLBT_SUPPLY_PAGE);
	wire logic rd_cap = ra_word && (ra[7:4] == plbt_pkg::PLBT_CAPTURE_PAGE);
	wire logic rd_ctrl = (ra == plbt_pkg::PLBT_REG_CTRL);
	wire logic rd_stat = (ra == plbt_pkg::PLBT_REG_STATUS);
	wire logic rd_addr = (ra == plbt_pkg::PLBT_REG_ADDR);
	wire logic rd_ok = rd_sup || rd_cap || rd_ctrl || rd_stat || rd_addr;
	wire logic [31:0] status_word = {20'h0_0000, cnt_r, 4'h0, region_r,
		dir_r, (state_r != plbt_pkg::H_IDLE)};
	wire logic [31:0] rd_word = rd_ctrl ? ctrl_r
		: rd_stat ? status_word
		: rd_addr ? addr_cap_r
		: rd_sup ? supply_r[ra[3:2]]
		: rd_cap ? capture_r[ra[3:2]]
		: plbt_pkg::PLBT_WORD_ZERO;

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= plbt_pkg::PLBT_WORD_ZERO;
			s_axi_rresp  <= plbt_pkg::PLBT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? plbt_pkg::PLBT_RESP_OKAY
				: plbt_pkg::PLBT_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : plbt_servicer
`default_nettype wire

// ---- verilog/plbt_pkg.sv ----
// Shared constants and types of the pass-through local-bus port.
`default_nettype none
package plbt_pkg;
	// Local-bus register index of the data port.
	localparam logic [7:0] PLBT_DATA_PORT_OFS = 8'h2C;
	localparam logic [4:0] PLBT_DATA_PORT_IDX = PLBT_DATA_PORT_OFS[6:2];
	localparam logic [4:0] PLBT_IDX_NONE      = 5'h00;
	// Storage shape.
	localparam int         PLBT_DEPTH = 4;
	localparam int         PLBT_PTR_W = 2;
	localparam int         PLBT_CNT_W = 3;
	localparam logic [2:0] PLBT_ONE_PHASE = 3'h1;
	localparam logic [2:0] PLBT_TWO_PHASE = 3'h2;
	// Region width codes.
	localparam logic [1:0] PLBT_WIDTH_8  = 2'h0;
	localparam logic [1:0] PLBT_WIDTH_16 = 2'h1;
	localparam logic [1:0] PLBT_WIDTH_32 = 2'h2;
	// Reset values.
	localparam logic [3:0]  PLBT_MASK_NONE = 4'hF;
	localparam logic [31:0] PLBT_WORD_ZERO = 32'h0000_0000;
	// Servicer register map.
	localparam logic [7:0] PLBT_REG_CTRL     = 8'h00;
	localparam logic [7:0] PLBT_REG_STATUS   = 8'h04;
	localparam logic [7:0] PLBT_REG_ADDR     = 8'h08;
	localparam logic [3:0] PLBT_SUPPLY_PAGE  = 4'h1;
	localparam logic [3:0] PLBT_CAPTURE_PAGE = 4'h2;
	// Control fields.
	localparam int          PLBT_CTRL_FETCH  = 0;
	localparam int          PLBT_CTRL_WAIT   = 1;
	localparam int          PLBT_CTRL_ENABLE = 2;
	localparam logic [31:0] PLBT_CTRL_RST    = 32'h0000_0005;
	localparam logic [31:0] PLBT_CTRL_MASK   = 32'h0000_0007;
	// Status fields.
	localparam int PLBT_STAT_BUSY   = 0;
	localparam int PLBT_STAT_DIR    = 1;
	localparam int PLBT_STAT_REGION = 2;
	localparam int PLBT_STAT_COUNT  = 8;
	// AXI responses.
	localparam logic [1:0] PLBT_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PLBT_RESP_SLVERR = 2'h2;
	// State machines.
	typedef enum logic [0:0] {DEV_IDLE, DEV_ACTIVE} plbt_dev_state_type;
	typedef enum logic [2:0] {
		H_IDLE, H_ADDR, H_TURN, H_RDREQ, H_RDCAP, H_WAIT, H_PHASE, H_END
	} plbt_host_state_type;
endpackage : plbt_pkg
`default_nettype wire

// ---- verilog/plbt_pin_if.sv ----
// Local-bus pins joining the pass-through target and its servicer.
`timescale 1ns/1ps
`default_nettype none
interface plbt_pin_if;
	logic        passthru_attention_n;
	logic        multi_phase_n;
	logic [1:0]  region_index;
	logic        transfer_direction;
	logic [3:0]  pending_byte_mask_n;
	logic        addr_strobe_n;
	logic        phase_done_n;
	logic [3:0]  lane_enable_n;
	logic        chip_select_n;
	logic [4:0]  reg_index;
	logic        rd_n;
	logic        wr_n;
	logic [31:0] dev_dq_out;
	logic        dev_dq_oe;
	logic [31:0] loc_dq_out;
	logic        loc_dq_oe;
	logic [31:0] dq;

	// Resolved level of the shared data bus; an undriven bus reads zero.
	assign dq = dev_dq_oe ? dev_dq_out
		: (loc_dq_oe ? loc_dq_out : plbt_pkg::PLBT_WORD_ZERO);

	modport target (
		output passthru_attention_n, multi_phase_n, region_index,
		output transfer_direction, pending_byte_mask_n,
		output dev_dq_out, dev_dq_oe,
		input  addr_strobe_n, phase_done_n, lane_enable_n, chip_select_n,
		input  reg_index, rd_n, wr_n, dq
	);
	modport servicer (
		input  passthru_attention_n, multi_phase_n, region_index,
		input  transfer_direction, pending_byte_mask_n,
		output loc_dq_out, loc_dq_oe,
		output addr_strobe_n, phase_done_n, lane_enable_n, chip_select_n,
		output reg_index, rd_n, wr_n,
		input  dq
	);
endinterface : plbt_pin_if
`default_nettype wire

// ---- verilog/plbt_lane_steer.sv ----
// Byte-lane steering between the data port word and the local data bus.
`timescale 1ns/1ps
`default_nettype none
module plbt_lane_steer (
	// Stored word and lane selection
	input  wire logic [31:0] word,
	input  wire logic [3:0]  lane_enable_n,
	input  wire logic [1:0]  width,
	// Local data bus
	input  wire logic [31:0] dq_in,
	// Steered results
	output logic      [31:0] rd_out,
	output logic      [31:0] wr_bytes
);
	wire logic [7:0] b1 = word[15:8];
	wire logic [7:0] b2 = word[23:16];
	wire logic [7:0] b3 = word[31:24];

	// The lowest enabled lane picks the byte that is copied downward.
	assign rd_out = !lane_enable_n[0] ? word
		: !lane_enable_n[1] ? {word[31:8], b1}
		: !lane_enable_n[2] ? {word[31:16], b2, b2}
		: !lane_enable_n[3] ? {b3, b3, b3, b3}
		: word;

	// Narrow regions gather every byte from the low lanes.
	assign wr_bytes = (width == plbt_pkg::PLBT_WIDTH_8) ? {4{dq_in[7:0]}}
		: (width == plbt_pkg::PLBT_WIDTH_16) ? {2{dq_in[15:0]}}
		: dq_in;
endmodule : plbt_lane_steer
`default_nettype wire

// ---- verilog/plbt_target.sv ----
// Pass-through target: the device end of the local-bus pass-through port.
`timescale 1ns/1ps
`default_nettype none
module plbt_target (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Local-bus pins
	plbt_pin_if.target       pins,
	// Host-side access request
	input  wire logic        acc_start,
	input  wire logic [31:0] acc_addr,
	input  wire logic [1:0]  acc_region,
	input  wire logic        acc_write,
	input  wire logic [2:0]  acc_phases,
	input  wire logic [3:0]  acc_byte_en_n,
	input  wire logic [plbt_pkg::PLBT_DEPTH-1:0][31:0] acc_wdata,
	// Boot-time width of each region
	input  wire logic [3:0][1:0] region_width,
	// Host-side status and results
	output logic             acc_idle,
	output logic             acc_done,
	output logic [plbt_pkg::PLBT_DEPTH-1:0][31:0] acc_rdata
);
	plbt_pkg::plbt_dev_state_type state_r;
	plbt_pkg::plbt_dev_state_type state_nxt;

	logic [31:0]                     addr_r;
	logic [1:0]                      region_r;
	logic [1:0]                      width_r;
	logic                            dir_r;
	logic [3:0]                      be_n_r;
	logic [plbt_pkg::PLBT_CNT_W-1:0] remain_r;
	logic [plbt_pkg::PLBT_CNT_W-1:0] remain_nxt;
	logic [plbt_pkg::PLBT_PTR_W-1:0] ptr_r;
	logic [plbt_pkg::PLBT_PTR_W-1:0] ptr_nxt;
	logic [3:0]                      mask_n_r;
	logic [3:0]                      mask_n_nxt;
	logic                            burst_n_r;
	logic                            burst_n_nxt;
	logic                            atn_n_r;
	logic                            atn_n_nxt;
	logic                            done_r;
	logic                            done_nxt;
	logic [plbt_pkg::PLBT_DEPTH-1:0][31:0] store_r;
	logic [31:0]                     rd_dq_r;
	logic                            rd_oe_r;
	logic [31:0]                     steer_rd;
	logic [31:0]                     steer_wr;
	logic [31:0]                     word_nxt;

	// Access decoding on the local bus.
	wire logic active = (state_r == plbt_pkg::DEV_ACTIVE);
	wire logic start_hit = (state_r == plbt_pkg::DEV_IDLE) && acc_start;
	wire logic port_hit = !pins.chip_select_n
		&& (pins.reg_index == plbt_pkg::PLBT_DATA_PORT_IDX);
	wire logic rd_hit = active && port_hit && !pins.rd_n;
	wire logic wr_hit = active && port_hit && !pins.wr_n;
	wire logic done_hit = active && !pins.phase_done_n;
	wire logic [2:0] phases_eff = (acc_phases == 3'h0)
		? plbt_pkg::PLBT_ONE_PHASE : acc_phases;
	wire logic [31:0] cur_word = store_r[ptr_r];
	wire logic [3:0] rd_lane = {4{rd_hit}} & ~pins.lane_enable_n;
	wire logic [3:0] wr_lane = {4{wr_hit}} & ~mask_n_r
		& ~pins.lane_enable_n;

	plbt_lane_steer u_steer (
		.word          (cur_word),
		.lane_enable_n (pins.lane_enable_n),
		.width         (width_r),
		.dq_in         (pins.dq),
		.rd_out        (steer_rd),
		.wr_bytes      (steer_wr)
	);

	// Only lanes that are both pending and enabled take new bytes.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
			assign word_nxt[gi*8 +: 8] = wr_lane[gi]
				? steer_wr[gi*8 +: 8] : cur_word[gi*8 +: 8];
		end
	endgenerate

	always_comb begin
		state_nxt   = state_r;
		remain_nxt  = remain_r;
		ptr_nxt     = ptr_r;
		burst_n_nxt = burst_n_r;
		atn_n_nxt   = atn_n_r;
		done_nxt    = 1'b0;
		mask_n_nxt  = mask_n_r | rd_lane | wr_lane;
		case (state_r)
			plbt_pkg::DEV_IDLE: begin
				if (acc_start) begin
					state_nxt   = plbt_pkg::DEV_ACTIVE;
					atn_n_nxt   = 1'b0;
					burst_n_nxt = (phases_eff == plbt_pkg::PLBT_ONE_PHASE);
					remain_nxt  = phases_eff;
					ptr_nxt     = '0;
					mask_n_nxt  = acc_byte_en_n;
				end
			end
			plbt_pkg::DEV_ACTIVE: begin
				if (done_hit) begin
					if (remain_r == plbt_pkg::PLBT_ONE_PHASE) begin
						state_nxt   = plbt_pkg::DEV_IDLE;
						atn_n_nxt   = 1'b1;
						burst_n_nxt = 1'b1;
						mask_n_nxt  = plbt_pkg::PLBT_MASK_NONE;
						done_nxt    = 1'b1;
					end else begin
						remain_nxt  = remain_r - plbt_pkg::PLBT_ONE_PHASE;
						ptr_nxt     = ptr_r + 2'h1;
						mask_n_nxt  = be_n_r;
						burst_n_nxt = (remain_r == plbt_pkg::PLBT_TWO_PHASE);
					end
				end
			end
			default: begin
				state_nxt = plbt_pkg::DEV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r   <= plbt_pkg::DEV_IDLE;
			atn_n_r   <= 1'b1;
			burst_n_r <= 1'b1;
			mask_n_r  <= plbt_pkg::PLBT_MASK_NONE;
			remain_r  <= '0;
			ptr_r     <= '0;
			done_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			atn_n_r   <= atn_n_nxt;
			burst_n_r <= burst_n_nxt;
			mask_n_r  <= mask_n_nxt;
			remain_r  <= remain_nxt;
			ptr_r     <= ptr_nxt;
			done_r    <= done_nxt;
		end
	end

	// Access attributes are held for the whole access.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_r   <= plbt_pkg::PLBT_WORD_ZERO;
			region_r <= 2'h0;
			dir_r    <= 1'b0;
			be_n_r   <= plbt_pkg::PLBT_MASK_NONE;
			width_r  <= plbt_pkg::PLBT_WIDTH_32;
		end else if (start_hit) begin
			addr_r   <= acc_addr;
			region_r <= acc_region;
			dir_r    <= acc_write;
			be_n_r   <= acc_byte_en_n;
			width_r  <= region_width[acc_region];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			store_r <= '0;
		end else if (start_hit && acc_write) begin
			store_r <= acc_wdata;
		end else if (wr_hit) begin
			store_r[ptr_r] <= word_nxt;
		end
	end

	// Read data is driven in the cycle after the read is sampled.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_oe_r <= 1'b0;
			rd_dq_r <= plbt_pkg::PLBT_WORD_ZERO;
		end else begin
			rd_oe_r <= rd_hit;
			rd_dq_r <= steer_rd;
		end
	end

	// The address fetch bypasses the clock entirely.
	assign pins.dev_dq_oe  = !pins.addr_strobe_n || rd_oe_r;
	assign pins.dev_dq_out = !pins.addr_strobe_n ? addr_r : rd_dq_r;

	assign pins.passthru_attention_n = atn_n_r;
	assign pins.multi_phase_n        = burst_n_r;
	assign pins.region_index         = region_r;
	assign pins.transfer_direction   = dir_r;
	assign pins.pending_byte_mask_n  = mask_n_r;

	assign acc_idle  = !active;
	assign acc_done  = done_r;
	assign acc_rdata = store_r;
endmodule : plbt_target
`default_nettype wire

// ---- verilog/unused_placeholder_check.sv ----
// Empty source unit of the pass-through port; it holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- bench/plbt_asserts.sv ----
// Concurrent checks on the local-bus pins between target and servicer.
`timescale 1ns/1ps
`default_nettype none
module plbt_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Local-bus pins
	input wire logic        passthru_attention_n,
	input wire logic        multi_phase_n,
	input wire logic [3:0]  pending_byte_mask_n,
	input wire logic        addr_strobe_n,
	input wire logic        phase_done_n,
	input wire logic [3:0]  lane_enable_n,
	input wire logic        chip_select_n,
	input wire logic [4:0]  reg_index,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        loc_dq_oe,
	input wire logic        dev_dq_oe,
	input wire logic [31:0] dq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_last;
		!passthru_attention_n && multi_phase_n && !phase_done_n;
	endsequence
	sequence s_port_rd;
		!passthru_attention_n && !rd_n && !chip_select_n && phase_done_n
			&& reg_index == plbt_pkg::PLBT_DATA_PORT_IDX;
	endsequence
	a_reset_idle: assert property (disable iff (1'h0) sys_rst |=>
		passthru_attention_n && multi_phase_n
		&& pending_byte_mask_n == plbt_pkg::PLBT_MASK_NONE)
		else $error("status not idle after reset");
	a_addr_drive: assert property (!addr_strobe_n |-> dev_dq_oe)
		else $error("address strobe without data drive");
	a_turn_gap: assert property ($rose(addr_strobe_n) |-> !loc_dq_oe)
		else $error("servicer drives bus in turnaround");
	a_wait_holds: assert property (
		(!passthru_attention_n && rd_n && wr_n && phase_done_n) |=>
		!passthru_attention_n && $stable(pending_byte_mask_n)
		&& $stable(multi_phase_n))
		else $error("state moved during wait state");
	a_last_done: assert property (s_last |=> passthru_attention_n
		&& pending_byte_mask_n == plbt_pkg::PLBT_MASK_NONE)
		else $error("attention kept after final phase");
	a_last_release: assert property (s_last |=> wr_n && rd_n
		&& chip_select_n && phase_done_n && !loc_dq_oe
		&& lane_enable_n == plbt_pkg::PLBT_MASK_NONE)
		else $error("servicer kept strobes after final phase");
	a_flag_rise: assert property ($rose(multi_phase_n) |->
		!$past(phase_done_n))
		else $error("burst flag rose without phase done");
	a_flag_needs: assert property (!multi_phase_n |->
		!passthru_attention_n)
		else $error("burst flag without attention");
	a_read_clears: assert property (s_port_rd |=>
		(~$past(lane_enable_n) & ~pending_byte_mask_n) == 4'h0)
		else $error("read lane still pending");
	a_read_steer: assert property (s_port_rd ##0 lane_enable_n == 4'h7
		|=> dev_dq_oe && dq == {4{dq[31:24]}})
		else $error("top byte not on all lanes");
endmodule : plbt_asserts
`default_nettype wire

// ---- bench/passthru_local_bus_target_bench.sv ----
// Self-checking bench joining the pass-through target and its servicer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
	failures++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module passthru_local_bus_target_bench;
	logic             clk = 1'h0, sys_rst = 1'h1;
	logic             acc_start = 1'h0, acc_write = 1'h0;
	logic [1:0]       acc_region = 2'h0;
	logic [2:0]       acc_phases = 3'h2;
	logic [3:0]       acc_byte_en_n = 4'h0;
	logic [31:0]      acc_addr = 32'h0000_0000;
	logic [3:0][31:0] acc_wdata = '0;
	logic [3:0][31:0] acc_rdata;
	logic             acc_idle, acc_done, awr, wr, bv, arr, rv;
	logic             awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [7:0]       awa = 8'h00, ara = 8'h00;
	logic [31:0]      wd = 32'h0000_0000, rd;
	logic [1:0]       bresp, rresp, xb;
	logic [33:0]      exp_r[$];
	logic [1:0]       exp_b[$];
	logic [63:0]      exp_h[$];
	logic [33:0]      xr;
	logic [63:0]      xh, gh;
	int               failures = 0, n_compared = 0, cyc = 0;

	plbt_pin_if pif ();
	plbt_target plbt_target_inst (
		.clk(clk), .sys_rst(sys_rst), .pins(pif.target),
		.acc_start(acc_start), .acc_addr(acc_addr), .acc_region(acc_region),
		.acc_write(acc_write), .acc_phases(acc_phases),
		.acc_byte_en_n(acc_byte_en_n),
		.acc_wdata(acc_wdata), .region_width({2'h2, 2'h2, 2'h1, 2'h0}),
		.acc_idle(acc_idle), .acc_done(acc_done), .acc_rdata(acc_rdata));
	plbt_servicer plbt_servicer_inst (
		.clk(clk), .sys_rst(sys_rst), .pins(pif.servicer),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp));
	plbt_asserts plbt_asserts_inst (
		.clk(clk), .sys_rst(sys_rst),
		.passthru_attention_n(pif.passthru_attention_n),
		.multi_phase_n(pif.multi_phase_n),
		.pending_byte_mask_n(pif.pending_byte_mask_n),
		.addr_strobe_n(pif.addr_strobe_n), .phase_done_n(pif.phase_done_n),
		.lane_enable_n(pif.lane_enable_n), .chip_select_n(pif.chip_select_n),
		.reg_index(pif.reg_index), .rd_n(pif.rd_n), .wr_n(pif.wr_n),
		.loc_dq_oe(pif.loc_dq_oe), .dev_dq_oe(pif.dev_dq_oe), .dq(pif.dq));

	always #20 clk = ~clk;

	task automatic summarize;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end

	// Results are matched against the oldest note as they appear.
	always @(posedge clk) begin
		if (rv && rr) begin
			xr = exp_r.pop_front();
			`CHK("axi read", xr, {rresp, rd})
		end
		if (bv && br) begin
			xb = exp_b.pop_front();
			`CHK("axi response", xb, bresp)
		end
		if (acc_done && !acc_write) begin
			xh = exp_h.pop_front();
			gh = {acc_rdata[1], acc_rdata[0]};
			`CHK("host words", xh, gh)
		end
		if (acc_done) begin
			`CHK("idle after access", 1'h1, acc_idle)
		end
	end

	task automatic axi_w(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic ap, wp;
		ap = 1'h1;
		wp = 1'h1;
		exp_b.push_back(e);
		@(posedge clk);
		awv <= 1'h1; awa <= a; wv <= 1'h1; wd <= d; br <= 1'h1;
		while (ap || wp) begin
			@(posedge clk);
			if (ap && awr) begin ap = 1'h0; awv <= 1'h0; end
			if (wp && wr) begin wp = 1'h0; wv <= 1'h0; end
		end
		while (!bv) @(posedge clk);
		br <= 1'h0;
	endtask : axi_w

	task automatic axi_r(input logic [7:0] a, input logic [33:0] e);
		exp_r.push_back(e);
		@(posedge clk);
		arv <= 1'h1; ara <= a; rr <= 1'h1;
		do @(posedge clk); while (!arr);
		arv <= 1'h0;
		while (!rv) @(posedge clk);
		rr <= 1'h0;
	endtask : axi_r

	task automatic host(input logic w, input logic [1:0] g,
		input logic [31:0] a);
		@(posedge clk);
		acc_start <= 1'h1; acc_write <= w; acc_region <= g; acc_addr <= a;
		@(posedge clk);
		acc_start <= 1'h0;
		while (!acc_done) @(posedge clk);
	endtask : host

	// Word as stored from the bus for a region of the given width code.
	function automatic logic [31:0] steer(input logic [31:0] d, input int g);
		if (g == 0) return {4{d[7:0]}};
		if (g == 1) return {2{d[15:0]}};
		return d;
	endfunction : steer

	initial begin
		logic [31:0] s0, s1, a;
		void'($urandom(19));
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		axi_r(8'h00, {2'h0, 32'h0000_0005});
		axi_r(8'h40, {2'h2, 32'h0000_0000});
		axi_w(8'h04, 32'h0000_0001, 2'h2);
		// Host reads over the 8, 16 and 32-bit regions, one with waits.
		for (int g = 0; g < 3; g++) begin
			s0 = $urandom;
			s1 = $urandom;
			a = $urandom;
			axi_w(8'h10, s0, 2'h0);
			axi_w(8'h14, s1, 2'h0);
			axi_w(8'h00, (g == 1) ? 32'h0000_0007 : 32'h0000_0005, 2'h0);
			exp_h.push_back({steer(s1, g), steer(s0, g)});
			host(1'h0, g[1:0], a);
			axi_r(8'h08, {2'h0, a});
		end
		// Host writes, drained byte by byte by the servicer.
		for (int g = 0; g < 4; g += 3) begin
			a = $urandom;
			acc_wdata <= {$urandom, $urandom, $urandom, $urandom};
			host(1'h1, g[1:0], a);
			axi_r(8'h20, {2'h0, acc_wdata[0]});
			axi_r(8'h24, {2'h0, acc_wdata[1]});
			axi_r(8'h04, {22'h0, 4'h2, 4'h0, g[1:0], 2'h2});
		end
		// One-phase host read without address fetch, bytes 0 and 2 only.
		s0 = $urandom;
		axi_w(8'h10, s0, 2'h0);
		axi_w(8'h00, 32'h0000_0004, 2'h0);
		acc_phases <= 3'h1;
		acc_byte_en_n <= 4'hA;
		exp_h.push_back({acc_wdata[1], acc_wdata[0][31:24], s0[23:16],
			acc_wdata[0][15:8], s0[7:0]});
		host(1'h0, 2'h2, $urandom);
		axi_r(8'h08, {2'h0, a});
		axi_r(8'h04, {22'h0, 4'h1, 4'h0, 2'h2, 2'h0});
		summarize();
	end
endmodule : passthru_local_bus_target_bench
`default_nettype wire
